// file: isl_pkg.sv
// package: constants, carrier types and helpers of the indicator selector
// ============================================================================
package isl_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_LAMPS = 6;
  localparam int NUM_SRC   = 40;
  localparam int SEL_W     = 6;
  localparam int NUM_PORTS = 8;
  localparam int NUM_TASKS = 10;
  localparam int NUM_WINK  = 12;
  localparam int WINK_W    = 25;
  localparam int MS_W      = 18;
  localparam int BLINK_W   = 10;
  localparam int LEN_W     = 16;
  localparam int LOAD_W    = 7;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STAT_W    = 4;

  // ==========================================================================
  // timing
  localparam int CLK_KHZ       = 250000;
  localparam int WINK_MS       = 100;
  localparam int WINK_CYC_DEF  = WINK_MS * CLK_KHZ;
  localparam int MS_CYC_DEF    = CLK_KHZ;
  localparam logic [BLINK_W-1:0] BLINK_BASE_MS = 10'h032;
  localparam logic [BLINK_W-1:0] BLINK_STEP_MS = 10'h004;

  // ==========================================================================
  // source numbers
  localparam logic [SEL_W-1:0] SRC_OFF       = 6'h00;
  localparam logic [SEL_W-1:0] SRC_ON        = 6'h01;
  localparam logic [SEL_W-1:0] SRC_TASK0     = 6'h02;
  localparam logic [SEL_W-1:0] SRC_REDUCED   = 6'h0C;
  localparam logic [SEL_W-1:0] SRC_LATE_ENC  = 6'h0D;
  localparam logic [SEL_W-1:0] SRC_LATE_DEC  = 6'h0E;
  localparam logic [SEL_W-1:0] SRC_SPARE     = 6'h0F;
  localparam logic [SEL_W-1:0] SRC_PORT0     = 6'h10;
  localparam logic [SEL_W-1:0] SRC_PEAK_LAT  = 6'h20;
  localparam logic [SEL_W-1:0] SRC_ANY_PEAK  = 6'h21;
  localparam logic [SEL_W-1:0] SRC_ANY_ACT   = 6'h22;
  localparam logic [SEL_W-1:0] SRC_VOICE     = 6'h23;
  localparam logic [SEL_W-1:0] SRC_LOAD      = 6'h24;
  localparam logic [SEL_W-1:0] SRC_ERR       = 6'h25;

  // wink slots: 0..7 port peaks, then these
  localparam int WK_ANY  = 8;
  localparam int WK_ENC  = 9;
  localparam int WK_DEC  = 10;
  localparam int WK_ERR  = 11;

  // ==========================================================================
  // register map (word aligned byte addresses)
  localparam logic [ADDR_W-1:0] REG_SEL0   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LIMIT  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] REG_MASK   = 8'h24;
  localparam logic [ADDR_W-1:0] REG_LAMPS  = 8'h28;
  localparam int CTRL_SAVE_BIT = 0;
  localparam int ST_PEAK = 0;
  localparam int ST_ENC  = 1;
  localparam int ST_DEC  = 2;
  localparam int ST_ERR  = 3;
  localparam logic [LEN_W-1:0]  LIMIT_RST = 16'hFFFF;
  localparam logic [STAT_W-1:0] MASK_RST  = 4'h0;

  // ==========================================================================
  // carriers
  typedef logic [NUM_LAMPS-1:0][SEL_W-1:0] isl_sel_set_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } isl_bus_req_t;

  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic             done;
  } isl_frame_t;

  // ==========================================================================
  // helpers
  function automatic logic isl_over_limit(input isl_frame_t f,
                                          input logic [LEN_W-1:0] lim);
    return f.done && (f.len > lim);
  endfunction : isl_over_limit

  function automatic logic [BLINK_W-1:0] isl_blink_half(
      input logic [LOAD_W-1:0] load);
    return BLINK_BASE_MS + BLINK_STEP_MS * BLINK_W'(load);
  endfunction : isl_blink_half

endpackage : isl_pkg

// file: isl_indicator_selector.sv
// module: routes forty status sources onto six front-panel lamps
//
// Our own choices: the register addresses and the address-and-strobe port.
module isl_indicator_selector #(
  parameter int WINK_CYCLES = isl_pkg::WINK_CYC_DEF,
  parameter int MS_CYCLES   = isl_pkg::MS_CYC_DEF
) (
  // clock and reset
  input  wire logic                              sys_clk_in,
  input  wire logic                              reset_n_in,
  // register port
  input  wire isl_pkg::isl_bus_req_t             bus_req_in,
  output logic [isl_pkg::DATA_W-1:0]             bus_rdata_out,
  // per-port detectors: aud tx, aud rx, pcm tx, pcm rx, voc tx/rx, com tx/rx
  input  wire logic [isl_pkg::NUM_PORTS-1:0]     port_peak_in,
  input  wire logic [isl_pkg::NUM_PORTS-1:0]     port_act_in,
  input  wire logic                              tone_peak_in,
  input  wire logic                              tone_act_in,
  // system conditions
  input  wire logic [isl_pkg::NUM_TASKS-1:0]     task_run_in,
  input  wire logic                              reduced_timing_in,
  input  wire logic                              enc_voice_in,
  input  wire logic                              enc_run_in,
  input  wire logic                              dec_voice_in,
  input  wire logic                              dec_run_in,
  input  wire logic                              err_level_in,
  input  wire logic                              add_drop_in,
  input  wire logic [isl_pkg::LOAD_W-1:0]        load_pct_in,
  input  wire isl_pkg::isl_frame_t               enc_frame_in,
  input  wire isl_pkg::isl_frame_t               dec_frame_in,
  // configuration storage
  input  wire logic                              cfg_restore_valid_in,
  input  wire isl_pkg::isl_sel_set_t             cfg_restore_data_in,
  output logic                                   cfg_save_req_out,
  output isl_pkg::isl_sel_set_t                  cfg_save_data_out,
  // lamps and interrupt
  output logic [isl_pkg::NUM_LAMPS-1:0]          lamp_out,
  output logic                                   irq_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    isl_pkg::isl_sel_set_t                               sel;
    logic [isl_pkg::LEN_W-1:0]                           limit;
    logic [isl_pkg::NUM_WINK-1:0][isl_pkg::WINK_W-1:0]   wink;
    logic                                                latched;
    logic [isl_pkg::MS_W-1:0]                            ms_cnt;
    logic [isl_pkg::BLINK_W-1:0]                         blink_cnt;
    logic                                                blink;
    logic [isl_pkg::STAT_W-1:0]                          status;
    logic [isl_pkg::STAT_W-1:0]                          mask;
    logic [isl_pkg::NUM_LAMPS-1:0]                       lamps;
    logic [isl_pkg::DATA_W-1:0]                          rdata;
    logic                                                irq;
    logic                                                save_req;
    isl_pkg::isl_sel_set_t                               save_data;
  } isl_state_t;

  isl_state_t                        st_ff;
  isl_state_t                        nxt_st;
  logic [isl_pkg::NUM_SRC-1:0]       src;
  logic [isl_pkg::NUM_WINK-1:0]      ev;
  logic                              any_peak;
  logic                              ms_tick;
  logic [isl_pkg::STAT_W-1:0]        st_ev;

  localparam logic [isl_pkg::WINK_W-1:0] WINK_LOAD =
    isl_pkg::WINK_W'(WINK_CYCLES);
  localparam logic [isl_pkg::MS_W-1:0] MS_LAST =
    isl_pkg::MS_W'(MS_CYCLES - 1);

  // ==========================================================================
  // event and source decode
  always_comb begin
    any_peak = (|port_peak_in) | tone_peak_in;
    ev = '0;
    ev[isl_pkg::NUM_PORTS-1:0] = port_peak_in;
    ev[isl_pkg::WK_ANY] = any_peak;
    ev[isl_pkg::WK_ENC] = isl_pkg::isl_over_limit(enc_frame_in,
                                                  st_ff.limit);
    ev[isl_pkg::WK_DEC] = isl_pkg::isl_over_limit(dec_frame_in,
                                                  st_ff.limit);
    ev[isl_pkg::WK_ERR] = add_drop_in;
    st_ev = '0;
    st_ev[isl_pkg::ST_PEAK] = any_peak;
    st_ev[isl_pkg::ST_ENC]  = ev[isl_pkg::WK_ENC];
    st_ev[isl_pkg::ST_DEC]  = ev[isl_pkg::WK_DEC];
    st_ev[isl_pkg::ST_ERR]  = add_drop_in;
    ms_tick = (st_ff.ms_cnt == MS_LAST);

    src = '0;
    src[isl_pkg::SRC_OFF] = 1'b0;
    src[isl_pkg::SRC_ON]  = 1'b1;
    for (int t = 0; t < isl_pkg::NUM_TASKS; t++) begin
      src[int'(isl_pkg::SRC_TASK0) + t] = task_run_in[t];
    end
    src[isl_pkg::SRC_REDUCED]  = reduced_timing_in;
    src[isl_pkg::SRC_LATE_ENC] = |st_ff.wink[isl_pkg::WK_ENC];
    src[isl_pkg::SRC_LATE_DEC] = |st_ff.wink[isl_pkg::WK_DEC];
    src[isl_pkg::SRC_SPARE]    = 1'b0;
    for (int p = 0; p < isl_pkg::NUM_PORTS; p++) begin
      // even ports are mixer outputs (tx), odd ports mixer inputs (rx)
      src[int'(isl_pkg::SRC_PORT0) + 2 * p]     = |st_ff.wink[p];
      src[int'(isl_pkg::SRC_PORT0) + 2 * p + 1] = port_act_in[p];
    end
    src[isl_pkg::SRC_PEAK_LAT] = st_ff.latched;
    src[isl_pkg::SRC_ANY_PEAK] = |st_ff.wink[isl_pkg::WK_ANY];
    src[isl_pkg::SRC_ANY_ACT]  = (|port_act_in) | tone_act_in;
    src[isl_pkg::SRC_VOICE]    = (enc_voice_in & enc_run_in)
                               | (dec_voice_in & dec_run_in);
    src[isl_pkg::SRC_LOAD]     = st_ff.blink;
    src[isl_pkg::SRC_ERR]      = err_level_in
                               | (|st_ff.wink[isl_pkg::WK_ERR]);
  end

  // ==========================================================================
  // next state
  always_comb begin
    logic [isl_pkg::ADDR_W-1:0] a;
    logic                       rd_status;
    a = bus_req_in.addr;
    rd_status = bus_req_in.rd && (a == isl_pkg::REG_STATUS);
    nxt_st = st_ff;

    // wink stretchers restart on every event
    for (int w = 0; w < isl_pkg::NUM_WINK; w++) begin
      if (ev[w]) begin
        nxt_st.wink[w] = WINK_LOAD;
      end else if (st_ff.wink[w] != '0) begin
        nxt_st.wink[w] = st_ff.wink[w] - 1'b1;
      end
    end

    // latched peak has no clearing path besides reset
    if (any_peak) begin
      nxt_st.latched = 1'b1;
    end

    // load blink: half period in ms grows with load
    nxt_st.ms_cnt = ms_tick ? '0 : st_ff.ms_cnt + 1'b1;
    if (ms_tick) begin
      if (st_ff.blink_cnt == '0) begin
        nxt_st.blink     = ~st_ff.blink;
        nxt_st.blink_cnt = isl_pkg::isl_blink_half(load_pct_in);
      end else begin
        nxt_st.blink_cnt = st_ff.blink_cnt - 1'b1;
      end
    end

    // restore from storage; a bus write in the same cycle takes precedence
    if (cfg_restore_valid_in) begin
      nxt_st.sel = cfg_restore_data_in;
    end

    // register writes
    nxt_st.save_req = 1'b0;
    if (bus_req_in.wr) begin
      for (int l = 0; l < isl_pkg::NUM_LAMPS; l++) begin
        if (a == isl_pkg::REG_SEL0 + isl_pkg::ADDR_W'(4 * l)) begin
          nxt_st.sel[l] = bus_req_in.wdata[isl_pkg::SEL_W-1:0];
        end
      end
      if (a == isl_pkg::REG_LIMIT) begin
        nxt_st.limit = bus_req_in.wdata[isl_pkg::LEN_W-1:0];
      end
      if (a == isl_pkg::REG_MASK) begin
        nxt_st.mask = bus_req_in.wdata[isl_pkg::STAT_W-1:0];
      end
      if (a == isl_pkg::REG_CTRL &&
          bus_req_in.wdata[isl_pkg::CTRL_SAVE_BIT]) begin
        nxt_st.save_req  = 1'b1;
        nxt_st.save_data = st_ff.sel;
      end
    end

    // status: read clears, a new event in the same cycle survives
    nxt_st.status = (rd_status ? '0 : st_ff.status) | st_ev;
    nxt_st.irq    = |(nxt_st.status & nxt_st.mask);

    // register reads, answered one cycle later
    nxt_st.rdata = '0;
    if (bus_req_in.rd) begin
      for (int l = 0; l < isl_pkg::NUM_LAMPS; l++) begin
        if (a == isl_pkg::REG_SEL0 + isl_pkg::ADDR_W'(4 * l)) begin
          nxt_st.rdata = isl_pkg::DATA_W'(st_ff.sel[l]);
        end
      end
      unique case (a)
        isl_pkg::REG_LIMIT:  nxt_st.rdata = isl_pkg::DATA_W'(st_ff.limit);
        isl_pkg::REG_STATUS: nxt_st.rdata = isl_pkg::DATA_W'(st_ff.status);
        isl_pkg::REG_MASK:   nxt_st.rdata = isl_pkg::DATA_W'(st_ff.mask);
        isl_pkg::REG_LAMPS:  nxt_st.rdata = isl_pkg::DATA_W'(st_ff.lamps);
        default:             nxt_st.rdata = nxt_st.rdata;
      endcase
    end

    // lamp routing; numbers past the table read dark
    for (int l = 0; l < isl_pkg::NUM_LAMPS; l++) begin
      nxt_st.lamps[l] = (int'(st_ff.sel[l]) < isl_pkg::NUM_SRC)
                      ? src[st_ff.sel[l]] : 1'b0;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff           <= '0;
      st_ff.sel[0]    <= isl_pkg::SRC_ANY_PEAK;
      st_ff.sel[1]    <= isl_pkg::SRC_ANY_ACT;
      st_ff.limit     <= isl_pkg::LIMIT_RST;
      st_ff.mask      <= isl_pkg::MASK_RST;
      st_ff.latched   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  always_comb begin
    lamp_out          = st_ff.lamps;
    bus_rdata_out     = st_ff.rdata;
    irq_out           = st_ff.irq;
    cfg_save_req_out  = st_ff.save_req;
    cfg_save_data_out = st_ff.save_data;
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_on_lit_lamp: assert property (
    (st_ff.sel[0] == isl_pkg::SRC_ON) [*2] |-> lamp_out[0])
    else $error("lamp on ON source is dark");

  a_off_dark_lamp: assert property (
    (st_ff.sel[3] == isl_pkg::SRC_OFF) [*2] |-> !lamp_out[3])
    else $error("lamp on OFF source is lit");

  a_spare_never_lit: assert property (
    (st_ff.sel[2] == isl_pkg::SRC_SPARE) [*2] |-> !lamp_out[2])
    else $error("lamp on spare source is lit");

  a_wink_load_count: assert property (
    ev[isl_pkg::WK_ANY] |=> st_ff.wink[isl_pkg::WK_ANY] == WINK_LOAD)
    else $error("peak wink not loaded with full length");

  a_wink_count_down: assert property (
    (st_ff.wink[isl_pkg::WK_ANY] != '0 && !ev[isl_pkg::WK_ANY])
    |=> st_ff.wink[isl_pkg::WK_ANY] ==
        $past(st_ff.wink[isl_pkg::WK_ANY]) - 1'b1)
    else $error("peak wink does not count down by one");

  a_latch_set_hold: assert property (
    any_peak |=> st_ff.latched [*2])
    else $error("latched peak not set or not held");

  a_latch_no_clear: assert property (
    st_ff.latched |=> st_ff.latched)
    else $error("latched peak cleared without reset");

  a_any_activity: assert property (
    (st_ff.sel[1] == isl_pkg::SRC_ANY_ACT && $stable(st_ff.sel[1])
     && port_act_in[5]) |=> lamp_out[1])
    else $error("activity on a port not shown on any-activity lamp");

  a_tx_peak_slot: assert property (
    port_peak_in[0] |=> st_ff.wink[0] == WINK_LOAD ##1
    (st_ff.sel[2] != isl_pkg::SRC_PORT0 || lamp_out[2]))
    else $error("transmit audio peak not winking its lamp");

  a_reduced_level: assert property (
    (st_ff.sel[5] == isl_pkg::SRC_REDUCED && reduced_timing_in)
    |=> lamp_out[5])
    else $error("reduced timing lamp dark while mode active");

  a_voice_lamp: assert property (
    (st_ff.sel[0] == isl_pkg::SRC_VOICE && enc_voice_in && !enc_run_in
     && !(dec_voice_in && dec_run_in)) |=> !lamp_out[0])
    else $error("voice lamp lit with encoder stopped");

  a_err_level_lit: assert property (
    (st_ff.sel[2] == isl_pkg::SRC_ERR && err_level_in) |=> lamp_out[2])
    else $error("error lamp dark during error condition");

  a_late_enc_wink: assert property (
    (enc_frame_in.done && enc_frame_in.len > st_ff.limit)
    |=> st_ff.wink[isl_pkg::WK_ENC] == WINK_LOAD)
    else $error("late encoder frame did not wink");

  a_late_dec_wink: assert property (
    (dec_frame_in.done && dec_frame_in.len <= st_ff.limit)
    |=> st_ff.wink[isl_pkg::WK_DEC] != WINK_LOAD)
    else $error("decoder frame within limit winked");

  a_blink_reload: assert property (
    $changed(st_ff.blink)
    |-> st_ff.blink_cnt == isl_pkg::isl_blink_half($past(load_pct_in)))
    else $error("blink half period does not follow load");

  a_task_marker: assert property (
    (st_ff.sel[3] == isl_pkg::SRC_TASK0 && task_run_in[0]) |=> lamp_out[3])
    else $error("task marker not shown on lamp");

  a_save_snapshot: assert property (
    cfg_save_req_out |-> cfg_save_data_out == $past(st_ff.sel)
    ##1 !cfg_save_req_out)
    else $error("saved selections differ or request too long");

endmodule : isl_indicator_selector

// file: isl_cfg_store_model.sv
// config storage model: keeps saved lamp selections, replays them on demand
module isl_cfg_store_model (
  // clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  // save side
  input  wire logic                  save_req_in,
  input  wire isl_pkg::isl_sel_set_t save_data_in,
  // restore side
  input  wire logic                  restore_go_in,
  output logic                       restore_valid_out,
  output isl_pkg::isl_sel_set_t      restore_data_out
);
  typedef struct packed {
    isl_pkg::isl_sel_set_t stored;
    logic                  valid;
  } isl_store_t;

  isl_store_t state_ff;
  isl_store_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.valid = restore_go_in;
    if (save_req_in) begin
      nxt_state.stored = save_data_in;
    end
  end

  // storage survives reset, only the replay strobe is cleared
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff.valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign restore_valid_out = state_ff.valid;
  // outside the strobe the data lines show the inverse, not a stale copy
  assign restore_data_out = state_ff.valid ? state_ff.stored
                                           : ~state_ff.stored;
endmodule : isl_cfg_store_model

// file: tb_top.sv
// testbench: lamp routing, winks, latch, status, blink, save and restore
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0] sel;
    logic [7:0] pact;
    logic [9:0] tsk;
    logic       red;
    logic [4:0] ev;
    logic       err;
    logic       exp;
  } isl_row_t;
  // ev: tone act, enc voice, enc run, dec voice, dec run
  localparam isl_row_t ROWS[17] = '{
    '{6'h00, 8'hFF, 10'h3FF, 1'b1, 5'h1F, 1'b1, 1'b0},
    '{6'h01, 8'h00, 10'h000, 1'b0, 5'h00, 1'b0, 1'b1},
    '{6'h05, 8'h00, 10'h008, 1'b0, 5'h00, 1'b0, 1'b1},
    '{6'h05, 8'hFF, 10'h3F7, 1'b1, 5'h1F, 1'b1, 1'b0},
    '{6'h0C, 8'h00, 10'h000, 1'b1, 5'h00, 1'b0, 1'b1},
    '{6'h0C, 8'hFF, 10'h3FF, 1'b0, 5'h1F, 1'b1, 1'b0},
    '{6'h1B, 8'h20, 10'h000, 1'b0, 5'h00, 1'b0, 1'b1},
    '{6'h1B, 8'hDF, 10'h3FF, 1'b1, 5'h1F, 1'b1, 1'b0},
    '{6'h13, 8'h02, 10'h000, 1'b0, 5'h00, 1'b0, 1'b1},
    '{6'h22, 8'h80, 10'h000, 1'b0, 5'h00, 1'b0, 1'b1},
    '{6'h22, 8'h00, 10'h3FF, 1'b1, 5'h0F, 1'b1, 1'b0},
    '{6'h23, 8'h00, 10'h000, 1'b0, 5'h0C, 1'b0, 1'b1},
    '{6'h23, 8'h00, 10'h000, 1'b0, 5'h09, 1'b0, 1'b0},
    '{6'h23, 8'h00, 10'h000, 1'b0, 5'h03, 1'b0, 1'b1},
    '{6'h23, 8'h00, 10'h000, 1'b0, 5'h06, 1'b0, 1'b0},
    '{6'h25, 8'h00, 10'h000, 1'b0, 5'h00, 1'b1, 1'b1},
    '{6'h0F, 8'hFF, 10'h3FF, 1'b1, 5'h1F, 1'b1, 1'b0}
  };
  logic                  sys_clk_in = 1'b0;
  logic                  reset_n_in = 1'b0;
  isl_pkg::isl_bus_req_t bus        = '0;
  logic [31:0]           rdata;
  logic [7:0]            peak       = '0;
  logic [7:0]            pact       = '0;
  logic [9:0]            tsk        = '0;
  logic [4:0]            ev         = '0;
  logic                  tone_pk    = 1'b0;
  logic                  red        = 1'b0;
  logic                  err        = 1'b0;
  logic                  adrop      = 1'b0;
  logic                  rst_go     = 1'b0;
  logic [6:0]            load       = '0;
  isl_pkg::isl_frame_t   enc_fr     = '0;
  isl_pkg::isl_frame_t   dec_fr     = '0;
  logic                  save_req;
  isl_pkg::isl_sel_set_t save_data;
  logic                  rvalid;
  isl_pkg::isl_sel_set_t rdata_cfg;
  logic [5:0]            lamp;
  logic                  irq;
  logic [31:0]           rd_v;
  int                    lit[6];
  int                    n_mismatch = 0;
  int                    n_compared = 0;
  int                    tf;
  int                    ts;

  isl_indicator_selector #(.WINK_CYCLES(20), .MS_CYCLES(4))
    i_isl_indicator_selector (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus_req_in(bus),
    .bus_rdata_out(rdata), .port_peak_in(peak), .port_act_in(pact),
    .tone_peak_in(tone_pk), .tone_act_in(ev[4]), .task_run_in(tsk),
    .reduced_timing_in(red), .enc_voice_in(ev[3]), .enc_run_in(ev[2]),
    .dec_voice_in(ev[1]), .dec_run_in(ev[0]), .err_level_in(err),
    .add_drop_in(adrop), .load_pct_in(load), .enc_frame_in(enc_fr),
    .dec_frame_in(dec_fr), .cfg_restore_valid_in(rvalid),
    .cfg_restore_data_in(rdata_cfg), .cfg_save_req_out(save_req),
    .cfg_save_data_out(save_data), .lamp_out(lamp), .irq_out(irq));

  isl_cfg_store_model i_isl_cfg_store_model (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .save_req_in(save_req),
    .save_data_in(save_data), .restore_go_in(rst_go),
    .restore_valid_out(rvalid), .restore_data_out(rdata_cfg));

  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic edge_n(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : edge_n

  task automatic check(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    edge_n(1);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    edge_n(1);
    bus <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, string w);
    edge_n(1);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    edge_n(1);
    bus <= '0;
    #1;
    check(w, 64'(rdata), 64'(e));
  endtask : bus_rd

  // lit cycles per lamp over a window longer than one wink
  task automatic measure();
    lit = '{default: 0};
    repeat (48) begin
      edge_n(1);
      #1;
      foreach (lit[k]) lit[k] += int'(lamp[k]);
    end
  endtask : measure

  task automatic toggles(input logic [6:0] l, output int n);
    load <= l;
    n = 0;
    edge_n(700);
    #1;
    rd_v[0] = lamp[5];
    repeat (1200) begin
      edge_n(1);
      #1;
      n += int'(rd_v[0] !== lamp[5]);
      rd_v[0] = lamp[5];
    end
  endtask : toggles

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    edge_n(6);
    check("reset outs", {lamp, irq, save_req}, 64'h0);
    reset_n_in <= 1'b1;
    bus_rd(8'h00, 32'h21, "sel0");
    bus_rd(8'h04, 32'h22, "sel1");
    bus_rd(8'h18, 32'hFFFF, "limit");
    bus_rd(8'h3C, 32'h0, "unmapped");
    ev <= 5'h10;
    edge_n(3);
    #1;
    check("lamp two default", lamp[1:0], 2'h2);
    foreach (ROWS[i]) begin
      bus_wr(8'(4 * (i % 6)), 32'(ROWS[i].sel));
      {pact, tsk, red, ev, err} <= {ROWS[i].pact, ROWS[i].tsk, ROWS[i].red,
                                   ROWS[i].ev, ROWS[i].err};
      edge_n(3);
      #1;
      check("row lamp", lamp[i % 6], ROWS[i].exp);
    end
    {pact, tsk, red, ev, err} <= '0;
    bus_wr(8'h00, 32'h20);
    bus_wr(8'h04, 32'h21);
    bus_wr(8'h08, 32'h10);
    edge_n(3);
    #1;
    check("latch idle", lamp[0], 1'b0);
    edge_n(1);
    tone_pk <= 1'b1;
    edge_n(1);
    tone_pk <= 1'b0;
    measure();
    check("latch lit", lit[0], 48);
    check("any peak wink", lit[1], 20);
    edge_n(1);
    peak <= 8'h01;
    edge_n(1);
    peak <= 8'h00;
    measure();
    check("port peak wink", lit[2], 20);
    bus_wr(8'h18, 32'h0064);
    bus_wr(8'h0C, 32'h0D);
    bus_wr(8'h10, 32'h0E);
    bus_wr(8'h14, 32'h25);
    for (int j = 0; j < 2; j++) begin
      edge_n(1);
      enc_fr <= '{len: 16'h0064 + 16'(j), done: 1'b1};
      dec_fr <= '{len: 16'h0065 - 16'(j), done: 1'b1};
      edge_n(1);
      enc_fr <= '0;
      dec_fr <= '0;
      measure();
      check("late enc", lit[3], 20 * j);
      check("late dec", lit[4], 20 - 20 * j);
    end
    check("irq masked", irq, 1'b0);
    bus_wr(8'h24, 32'h1);
    edge_n(1);
    #1;
    check("irq on", irq, 1'b1);
    bus_rd(8'h20, 32'h7, "status");
    check("irq cleared", {irq, lamp[0]}, 2'h1);
    edge_n(1);
    adrop <= 1'b1;
    edge_n(1);
    adrop <= 1'b0;
    measure();
    check("err wink", {irq, 8'(lit[5])}, 9'h014);
    bus_rd(8'h20, 32'h8, "status ad");
    bus_wr(8'h14, 32'h24);
    toggles(7'h00, tf);
    toggles(7'h19, ts);
    check("blink faster", tf > ts + 2, 1'b1);
    bus_wr(8'h0C, 32'h01);
    bus_wr(8'h1C, 32'h1);
    #1;
    check("save", {save_req, save_data[3]}, 7'h41);
    bus_wr(8'h0C, 32'h00);
    edge_n(1);
    rst_go <= 1'b1;
    edge_n(1);
    rst_go <= 1'b0;
    bus_rd(8'h0C, 32'h01, "restored");
    edge_n(1);
    reset_n_in <= 1'b0;
    edge_n(2);
    reset_n_in <= 1'b1;
    bus_wr(8'h00, 32'h20);
    edge_n(3);
    #1;
    check("latch reset", lamp[0], 1'b0);
    print_verdict();
  end
endmodule : tb_top
